/* File: rtl/sps_defs.svh */
// Constants of the stepper phase sequencer: state codes, drive bits and timing.
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// ------------------------------------------------------------
// Drive vector bit positions
// ------------------------------------------------------------
`define SPS_DRV_A 0
`define SPS_DRV_AB 1
`define SPS_DRV_B 2
`define SPS_DRV_BB 3
`define SPS_DRV_OFF 4'h0

// ------------------------------------------------------------
// Sequencer positions, one-hot, in forward order
// ------------------------------------------------------------
`define SPS_POS_0 8'h01
`define SPS_POS_1 8'h02
`define SPS_POS_2 8'h04
`define SPS_POS_3 8'h08
`define SPS_POS_4 8'h10
`define SPS_POS_5 8'h20
`define SPS_POS_6 8'h40
`define SPS_POS_7 8'h80
`define SPS_POS_SINGLE_MASK 8'haa
`define SPS_POS_RESET `SPS_POS_0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SPS_MCLK_PERIOD_NS 25
`define SPS_CLEAR_MIN_NS 20000
`define SPS_CLEAR_MIN_CYC ((`SPS_CLEAR_MIN_NS + `SPS_MCLK_PERIOD_NS - 1) / `SPS_MCLK_PERIOD_NS)

`endif

/* File: rtl/sps_pkg.sv */
// Types of the stepper phase sequencer.
`include "sps_defs.svh"

package sps_pkg;

  typedef enum logic [7:0] {
    SPS_P0 = `SPS_POS_0,
    SPS_P1 = `SPS_POS_1,
    SPS_P2 = `SPS_POS_2,
    SPS_P3 = `SPS_POS_3,
    SPS_P4 = `SPS_POS_4,
    SPS_P5 = `SPS_POS_5,
    SPS_P6 = `SPS_POS_6,
    SPS_P7 = `SPS_POS_7
  } sps_pos_e;

  typedef logic [3:0] sps_drive_t;

endpackage : sps_pkg

/* File: rtl/sps_sequencer.sv */
// Phase sequencer of a unipolar two-phase stepping motor driver.
//
// How it works
// - The winding state advances once per rising step clock edge outside clear and holds at all other times outside clear.
// - Mode low selects full-step two-phase excitation, mode high selects half-step one-two phase.
// - While the active-low system clear pin is low the sequencer resets and all four outputs are off.
// - After a clear with the step clock low the state drives the first winding forward and second return.
// - Half-step leaves each winding undriven for a quarter more time, giving three quarters of full-step drive.
// - The excitation mode is sampled only at a step clock rising edge.
`include "sps_defs.svh"

module sps_sequencer #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic mclk, // System clock, 40 MHz.
  input wire logic resetn, // Asynchronous active-low chip reset.
  input wire logic step_clk, // Step clock pin.
  input wire logic excite_mode, // Excitation mode pin.
  input wire logic direction_select, // Direction pin.
  input wire logic system_clear_n, // Active-low system clear pin.
  output logic phase_a, // First winding forward drive.
  output logic phase_ab, // First winding return drive.
  output logic phase_b, // Second winding forward drive.
  output logic phase_bb // Second winding return drive.
);
  import sps_pkg::*;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two.");
  end

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Winding drive for a position, forward order A+BB, A, A+B, B, B+AB, AB, AB+BB, BB.
  function automatic sps_drive_t drive_of(input sps_pos_e pos);
    sps_drive_t d;
    d = `SPS_DRV_OFF;
    case (pos)
      SPS_P0: begin
        d[`SPS_DRV_A] = 1'b1;
        d[`SPS_DRV_BB] = 1'b1;
      end
      SPS_P1: d[`SPS_DRV_A] = 1'b1;
      SPS_P2: begin
        d[`SPS_DRV_A] = 1'b1;
        d[`SPS_DRV_B] = 1'b1;
      end
      SPS_P3: d[`SPS_DRV_B] = 1'b1;
      SPS_P4: begin
        d[`SPS_DRV_B] = 1'b1;
        d[`SPS_DRV_AB] = 1'b1;
      end
      SPS_P5: d[`SPS_DRV_AB] = 1'b1;
      SPS_P6: begin
        d[`SPS_DRV_AB] = 1'b1;
        d[`SPS_DRV_BB] = 1'b1;
      end
      SPS_P7: d[`SPS_DRV_BB] = 1'b1;
      default: d = `SPS_DRV_OFF;
    endcase
    return d;
  endfunction : drive_of

  // Next position. Full-step moves two positions, or one from a single-phase
  // position so that a switch out of half-step lands on a two-phase state.
  function automatic sps_pos_e step_of(input sps_pos_e pos, input logic half, input logic rev);
    logic [7:0] p;
    logic one;
    p = pos;
    one = half | (|(p & `SPS_POS_SINGLE_MASK));
    case ({rev, one})
      2'b00: p = {p[5:0], p[7:6]};
      2'b01: p = {p[6:0], p[7]};
      2'b10: p = {p[1:0], p[7:2]};
      2'b11: p = {p[0], p[7:1]};
      default: p = `SPS_POS_RESET;
    endcase
    return sps_pos_e'(p);
  endfunction : step_of

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [SYNC_STAGES-1:0] step_sync_q;
  logic [SYNC_STAGES-1:0] mode_sync_q;
  logic [SYNC_STAGES-1:0] dir_sync_q;
  logic [SYNC_STAGES-1:0] clr_sync_q;
  logic step_prev_q;
  logic step_s;
  logic mode_s;
  logic dir_s;
  logic clr_s;
  logic step_edge;

  // The clear pin resets its stage to low so the block starts cleared.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_sync_q <= '0;
      mode_sync_q <= '0;
      dir_sync_q <= '0;
      clr_sync_q <= '0;
    end else begin
      step_sync_q <= {step_sync_q[SYNC_STAGES-2:0], step_clk};
      mode_sync_q <= {mode_sync_q[SYNC_STAGES-2:0], excite_mode};
      dir_sync_q <= {dir_sync_q[SYNC_STAGES-2:0], direction_select};
      clr_sync_q <= {clr_sync_q[SYNC_STAGES-2:0], system_clear_n};
    end
  end

  assign step_s = step_sync_q[SYNC_STAGES-1];
  assign mode_s = mode_sync_q[SYNC_STAGES-1];
  assign dir_s = dir_sync_q[SYNC_STAGES-1];
  assign clr_s = clr_sync_q[SYNC_STAGES-1];

  // Previous step level starts high, yet the step stage resets low, so a clock already high at reset still gives an edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev_q <= 1'b1;
    end else begin
      step_prev_q <= step_s;
    end
  end

  assign step_edge = step_s & ~step_prev_q;

  // ------------------------------------------------------------
  // Position state
  // ------------------------------------------------------------
  sps_pos_e pos_q;
  sps_pos_e pos_d;

  always_comb begin
    pos_d = pos_q;
    if (!clr_s) begin
      pos_d = sps_pos_e'(`SPS_POS_RESET);
    end else if (step_edge) begin
      pos_d = step_of(pos_q, mode_s, dir_s);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= SPS_P0;
    end else begin
      pos_q <= pos_d;
    end
  end

  // ------------------------------------------------------------
  // Winding outputs
  // ------------------------------------------------------------
  sps_drive_t drive_d;

  always_comb begin
    drive_d = `SPS_DRV_OFF;
    if (clr_s) begin
      drive_d = drive_of(pos_d);
    end
  end

  // Outputs are cut off during clear.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_a <= 1'b0;
      phase_ab <= 1'b0;
      phase_b <= 1'b0;
      phase_bb <= 1'b0;
    end else begin
      phase_a <= drive_d[`SPS_DRV_A];
      phase_ab <= drive_d[`SPS_DRV_AB];
      phase_b <= drive_d[`SPS_DRV_B];
      phase_bb <= drive_d[`SPS_DRV_BB];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic [3:0] out_vec;
  assign out_vec = {phase_bb, phase_b, phase_ab, phase_a};

  sequence s_clear_release;
    !clr_s ##1 clr_s;
  endsequence

  sequence s_step_taken;
    clr_s && step_edge;
  endsequence

  hold_when_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_s && !step_edge |=> $stable(pos_q))
    else $error("Position changed without a step edge.");

  advance_on_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_step_taken |=> pos_q != $past(pos_q))
    else $error("Position did not advance on a step edge.");

  full_two_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_step_taken and !mode_s) |=> $countones(out_vec) == 2)
    else $error("Full-step left a single-phase state.");

  fwd_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_step_taken and mode_s && !dir_s) |=> pos_q == sps_pos_e'({$past(pos_q[6:0]), $past(pos_q[7])}))
    else $error("Forward half-step order wrong.");

  rev_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_step_taken and mode_s && dir_s) |=> pos_q == sps_pos_e'({$past(pos_q[0]), $past(pos_q[7:1])}))
    else $error("Reverse half-step order wrong.");

  clear_cutoff_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clr_s |=> out_vec == `SPS_DRV_OFF && pos_q == SPS_P0)
    else $error("Outputs not cut off during clear.");

  init_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clear_release ##0 !step_edge |=> phase_a && phase_bb && !phase_ab && !phase_b)
    else $error("Initial state after clear is not first forward and second return.");

  drive_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_s |=> $countones(out_vec) inside {1, 2} && !(phase_a && phase_ab) && !(phase_b && phase_bb))
    else $error("Illegal winding drive combination.");

  mode_at_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_s && !step_edge && $changed(mode_s) |=> $stable(pos_q))
    else $error("Mode change acted without a step edge.");

  cycle_half_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_step_taken and !mode_s) |=> (pos_q & `SPS_POS_SINGLE_MASK) == 8'h00)
    else $error("Full-step landed on a single-phase position.");

endmodule : sps_sequencer

/* File: verification/sps_host_model.sv */
// Host controller model that drives the step, mode, direction and clear pins.
module sps_host_model (
  input wire logic mclk, // System clock.
  output logic step_clk, // Step clock pin.
  output logic excite_mode, // Excitation mode pin.
  output logic direction_select, // Direction pin.
  output logic system_clear_n // Active-low clear pin.
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    step_clk = 1'b0;
    excite_mode = 1'b0;
    direction_select = 1'b0;
    system_clear_n = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : wait_cyc

  // Mode and direction settle four cycles before the edge and hold well past it.
  task automatic step(input logic m, input logic d);
    wait_cyc(1);
    excite_mode = m;
    direction_select = d;
    wait_cyc(4);
    step_clk = 1'b1;
    wait_cyc(4);
    step_clk = 1'b0;
    wait_cyc(4);
  endtask : step

  task automatic clear(input int n);
    wait_cyc(1);
    system_clear_n = 1'b0;
    wait_cyc(n);
    system_clear_n = 1'b1;
    wait_cyc(6);
  endtask : clear
endmodule : sps_host_model

/* File: verification/stepper_phase_sequencer_bench.sv */
// Self-checking bench of the stepper phase sequencer against a position model.
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, s); end end

module stepper_phase_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sps_pkg::*;

  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic step_clk, excite_mode, direction_select, system_clear_n;
  logic phase_a, phase_ab, phase_b, phase_bb;
  sps_drive_t drv;
  int bad_count = 0;
  int comparisons = 0;
  int pos = 0;
  int ones;
  logic [31:0] rnd = 32'h432e3375;
  logic [3:0] tbl [8] = '{4'h9, 4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'ha, 4'h8};

  always #12.5 mclk = ~mclk;
  assign drv = {phase_bb, phase_b, phase_ab, phase_a};

  sps_host_model host (.mclk(mclk), .step_clk(step_clk), .excite_mode(excite_mode),
    .direction_select(direction_select), .system_clear_n(system_clear_n));

  sps_sequencer #(.SYNC_STAGES(2)) dut (.mclk(mclk), .resetn(resetn), .step_clk(step_clk),
    .excite_mode(excite_mode), .direction_select(direction_select), .system_clear_n(system_clear_n),
    .phase_a(phase_a), .phase_ab(phase_ab), .phase_b(phase_b), .phase_bb(phase_bb));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  // ------------------------------------------------------------
  // Step with model update
  // ------------------------------------------------------------
  // Full-step from a single-phase position moves one place, otherwise two.
  task automatic do_step(input logic m, input logic d);
    int inc;
    host.step(m, d);
    inc = (!m && pos % 2 == 0) ? 2 : 1;
    pos = d ? (pos + 8 - inc) % 8 : (pos + inc) % 8;
    `CHK("drive", tbl[pos], drv)
  endtask : do_step

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    #2 resetn = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    `CHK("drive in clear", 4'h0, drv)
    host.clear(800);
    `CHK("drive after clear", tbl[0], drv)
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr_next(rnd);
      do_step(rnd[0], rnd[1]);
      repeat (10) @(posedge mclk);
      #2;
      `CHK("drive held", tbl[pos], drv)
    end
    ones = 0;
    for (int i = 0; i < 8; i++) begin
      do_step(1'b1, 1'b0);
      ones += $countones(drv);
    end
    `CHK("half-step drive sum", 12, ones)
    // A clear in mid-run cuts the drive and ignores step edges until it lifts.
    fork
      host.clear(60);
      begin
        repeat (6) @(posedge mclk);
        #1;
        `CHK("drive cleared", 4'h0, drv)
        host.step(1'b1, 1'b0);
        `CHK("step during clear", 4'h0, drv)
      end
    join
    pos = 0;
    `CHK("drive after second clear", tbl[0], drv)
    do_step(1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    #(25 * 20000);
    bad_count++;
    tally_and_finish();
  end
endmodule : stepper_phase_sequencer_bench
